// >>> common/cgms_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: AXI4-Lite byte addresses, one register per aligned word
// Notes: none
`ifndef CGMS_MAP_SVH
`define CGMS_MAP_SVH
`define CGMS_OFF_CTRL1 8'h00
`define CGMS_OFF_CTRL2 8'h04
`define CGMS_OFF_TRIM 8'h08
`define CGMS_OFF_STAT 8'h0c
`define CGMS_OFF_CTRL3 8'h10
`define CGMS_RST_CTRL1 8'h04
`define CGMS_RST_CTRL2 8'h40
`define CGMS_RST_CTRL3 8'h01
`define CGMS_RST_TRIM 8'h80
`define CGMS_SRC_HI 7
`define CGMS_SRC_LO 6
`define CGMS_REFERENCE_DIVIDER_HI 5
`define CGMS_REFERENCE_DIVIDER_LO 3
`define CGMS_IREF_BIT 2
`define CGMS_BUS_DIVIDER_HI 7
`define CGMS_BUS_DIVIDER_LO 6
`define CGMS_RANGE_BIT 5
`define CGMS_HGO_BIT 4
`define CGMS_LP_BIT 3
`define CGMS_XTAL_BIT 2
`define CGMS_EREN_BIT 1
`define CGMS_IREN_BIT 0
`define CGMS_LSEL_BIT 6
`define CGMS_MUL_HI 3
`define CGMS_MUL_LO 0
`define CGMS_LOCK_BIT 6
`define CGMS_LST_BIT 5
`define CGMS_IRST_BIT 4
`define CGMS_CST_HI 3
`define CGMS_CST_LO 2
`define CGMS_OSCR_BIT 1
`define CGMS_FINE_TRIM_BIT_BIT 0
`define CGMS_CLK_NS 5
`define CGMS_OSC_START_NS 1000
`define CGMS_OSC_START_CYC \
  ((`CGMS_OSC_START_NS + `CGMS_CLK_NS - 1) / `CGMS_CLK_NS)
`define CGMS_LOCK_NS 2000
`define CGMS_LOCK_CYC ((`CGMS_LOCK_NS + `CGMS_CLK_NS - 1) / `CGMS_CLK_NS)
`define CGMS_FLL_MUL 1024
`endif

// >>> common/cgms_pkg.sv
package cgms_pkg;
  typedef enum logic [2:0] {
    cgms_fei, cgms_fee, cgms_fbe, cgms_fbi, cgms_pee, cgms_pbe,
    cgms_low_power_internal_bypass, cgms_low_power_external_bypass
  } cgms_mode_type;
  typedef struct packed {
    logic [1:0] src;
    logic [2:0] reference_divider;
    logic iref;
  } cgms_ctrl1_type;
  typedef struct packed {
    logic [1:0] bus_divider;
    logic range;
    logic high_gain_select;
    logic lp;
    logic xtal;
    logic eren;
    logic iren;
  } cgms_ctrl2_type;
  typedef struct packed {
    logic [7:0] ref_div;
    logic [10:0] mult;
    logic [3:0] bus_div;
  } cgms_freq_type;
endpackage

// >>> rtl/cgms_timer.sv
// Purpose: settle timer for oscillator start and loop lock
// Assumes: start restarts the count
// Notes: done is a level until the next start or clear
`timescale 1ns/1ps
`default_nettype none
module cgms_timer #(
  parameter int count = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic restart,
  // status
  output logic done
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_done;
  always_comb begin
    next_cnt = cnt;
    next_done = done;
    if (!run || restart) begin
      next_cnt = 32'h0;
      next_done = 1'b0;
    end else if (!done) begin
      if (cnt >= 32'(count - 1)) begin
        next_done = 1'b1;
      end
      next_cnt = cnt + 32'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 32'h0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/cgms_freq.sv
// Purpose: decodes divider codes into frequency factors per mode
// Assumes: registered output, one cycle behind the mode
// Notes: multiplier 1024 for FLL, code times 4 for PLL
`timescale 1ns/1ps
`default_nettype none
`include "cgms_map.svh"
module cgms_freq import cgms_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire cgms_mode_type mode,
  input wire logic [2:0] reference_divider,
  input wire logic [1:0] bus_divider,
  input wire logic [3:0] mul,
  // factors
  output cgms_freq_type factors
);
  cgms_freq_type next_factors;
  always_comb begin
    next_factors.ref_div = 8'h01 << reference_divider;
    next_factors.bus_div = 4'h1 << bus_divider;
    case (mode)
      cgms_fei, cgms_fee: begin
        next_factors.mult = 11'(`CGMS_FLL_MUL);
      end
      cgms_pee: begin
        next_factors.mult = {5'h0, mul, 2'h0};
      end
      default: begin
        next_factors.mult = 11'h001;
      end
    endcase
    if (mode == cgms_fei || mode == cgms_fbi || mode == cgms_low_power_internal_bypass) begin
      next_factors.ref_div = 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      factors <= '0;
    end else begin
      factors <= next_factors;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/cgms_core.sv
// Purpose: mode sequencer and register file of the clock generator
// Assumes: AXI4-Lite slave, 8-bit registers in low byte of each word
// Notes: bus clock enable pulses every other output cycle
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cgms_map.svh"
module cgms_core import cgms_pkg::*; #(
  parameter int osc_start_cyc = `CGMS_OSC_START_CYC,
  parameter int lock_cyc = `CGMS_LOCK_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // external source
  input wire logic ext_present,
  // clock outputs
  output cgms_mode_type mode,
  output cgms_freq_type factors,
  output logic bus_clk_en
);
  cgms_ctrl1_type ctrl1, next_ctrl1;
  cgms_ctrl2_type ctrl2, next_ctrl2;
  logic loop_sel, next_loop_sel;
  logic [3:0] mul, next_mul;
  logic [7:0] trim, next_trim;
  logic fine_trim_bit, next_fine_trim_bit;
  logic [1:0] clock_source_status, next_clock_source_status;
  logic loop_select_status, next_loop_select_status;
  logic iref_status, next_iref_status;
  cgms_mode_type next_mode;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic half, next_half;
  logic [1:0] ext_sync;
  logic osc_run, oscillator_ready, loop_locked, do_write;
  logic [7:0] wbyte, stat_byte;
  logic [1:0] want_src;

  // external presence passes two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync <= 2'b00;
    end else begin
      ext_sync <= {ext_sync[0], ext_present};
    end
  end

  assign osc_run = ctrl2.xtal && (ctrl2.eren || !ctrl1.iref);
  cgms_timer #(.count(osc_start_cyc)) u_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(osc_run && ext_sync[1]),
    .restart(1'b0),
    .done(oscillator_ready)
  );
  // lock restarts on a loop select or reference select status change, not on mul or divider writes; off in low power
  cgms_timer #(.count(lock_cyc)) u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!(mode == cgms_low_power_internal_bypass || mode == cgms_low_power_external_bypass)),
    .restart(next_iref_status != iref_status ||
             next_loop_select_status != loop_select_status),
    .done(loop_locked)
  );
  cgms_freq u_freq (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode),
    .reference_divider(ctrl1.reference_divider),
    .bus_divider(ctrl2.bus_divider),
    .mul(mul),
    .factors(factors)
  );

  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign wbyte = w_data[7:0];
  assign stat_byte = {1'b0, loop_locked, loop_select_status, iref_status,
                      clock_source_status, oscillator_ready,
                      fine_trim_bit};

  // software-controlled registers and bus slave
  always_comb begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_loop_sel = loop_sel;
    next_mul = mul;
    next_trim = trim;
    next_fine_trim_bit = fine_trim_bit;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      if (w_strb[0]) begin
        case ({aw_addr[7:2], 2'b00})
          `CGMS_OFF_CTRL1: begin
            next_ctrl1 = wbyte[7:2];
          end
          `CGMS_OFF_CTRL2: begin
            next_ctrl2 = wbyte;
          end
          `CGMS_OFF_CTRL3: begin
            next_loop_sel = wbyte[`CGMS_LSEL_BIT];
            next_mul = wbyte[`CGMS_MUL_HI:`CGMS_MUL_LO];
          end
          `CGMS_OFF_TRIM: begin
            next_trim = wbyte;
          end
          `CGMS_OFF_STAT: begin
            next_fine_trim_bit = wbyte[`CGMS_FINE_TRIM_BIT_BIT];
          end
          default: begin
            next_bresp = 2'b10;
          end
        endcase
      end else if (aw_addr > `CGMS_OFF_CTRL3) begin
        next_bresp = 2'b10;
      end
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      case ({araddr[7:2], 2'b00})
        `CGMS_OFF_CTRL1: begin
          next_rdata = {24'h0, ctrl1, 2'b00};
        end
        `CGMS_OFF_CTRL2: begin
          next_rdata = {24'h0, ctrl2};
        end
        `CGMS_OFF_CTRL3: begin
          next_rdata = {25'h0, loop_sel, 2'b00, mul};
        end
        `CGMS_OFF_TRIM: begin
          next_rdata = {24'h0, trim};
        end
        `CGMS_OFF_STAT: begin
          next_rdata = {24'h0, stat_byte};
        end
        default: begin
          next_rdata = 32'h0;
          next_rresp = 2'b10;
        end
      endcase
    end
  end

  // status mirroring and mode tracking
  always_comb begin
    // reference status only follows to an available reference
    next_iref_status = (ctrl1.iref || ext_sync[1]) ?
                       ctrl1.iref : iref_status;
    next_loop_select_status = loop_sel;
    next_clock_source_status = clock_source_status;
    want_src = 2'b00;
    case (ctrl1.src)
      2'b00: begin
        // pll needs lock before handing over
        if (loop_sel) begin
          want_src = (loop_locked && !ctrl1.iref && ext_sync[1]) ?
                     2'b11 : clock_source_status;
        end else begin
          want_src = (ctrl1.iref || ext_sync[1]) ?
                     2'b00 : clock_source_status;
        end
      end
      2'b01: begin
        want_src = 2'b01;
      end
      2'b10: begin
        want_src = (ext_sync[1] && (!ctrl2.xtal || oscillator_ready)) ?
                   2'b10 : clock_source_status;
      end
      default: begin
        want_src = clock_source_status;
      end
    endcase
    next_clock_source_status = want_src;
    next_mode = mode;
    case (want_src)
      2'b00: begin
        next_mode = next_iref_status ? cgms_fei : cgms_fee;
      end
      2'b11: begin
        next_mode = cgms_pee;
      end
      2'b01: begin
        next_mode = ctrl2.lp ? cgms_low_power_internal_bypass : cgms_fbi;
      end
      default: begin
        if (ctrl2.lp) begin
          next_mode = cgms_low_power_external_bypass;
        end else begin
          next_mode = loop_sel ? cgms_pbe : cgms_fbe;
        end
      end
    endcase
    // from reset mode only the three neighbours are reached
    if (mode == cgms_fei &&
        !(next_mode inside {cgms_fei, cgms_fee, cgms_fbe, cgms_fbi})) begin
      next_mode = cgms_fei;
      next_clock_source_status = clock_source_status;
    end
    next_half = !half;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1 <= cgms_ctrl1_type'(6'(`CGMS_RST_CTRL1 >> 2));
      ctrl2 <= `CGMS_RST_CTRL2;
      loop_sel <= 1'(`CGMS_RST_CTRL3 >> 6);
      mul <= 4'h1;
      trim <= `CGMS_RST_TRIM;
      fine_trim_bit <= 1'b0;
      clock_source_status <= 2'b00;
      loop_select_status <= 1'b0;
      iref_status <= 1'b1;
      mode <= cgms_fei;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0;
      half <= 1'b0;
    end else begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      loop_sel <= next_loop_sel;
      mul <= next_mul;
      trim <= next_trim;
      fine_trim_bit <= next_fine_trim_bit;
      clock_source_status <= next_clock_source_status;
      loop_select_status <= next_loop_select_status;
      iref_status <= next_iref_status;
      mode <= next_mode;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      half <= next_half;
    end
  end
  assign bus_clk_en = half;
endmodule
`default_nettype wire

// >>> testbench/cgms_core_asserts.sv
// Purpose: protocol and mode checks on the clock generator top
// Assumes: one clock domain, sync active-low reset
// Notes: bound into every cgms_core
`timescale 1ns/1ps
`default_nettype none
module cgms_core_asserts import cgms_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // clock outputs
  input wire cgms_mode_type mode,
  input wire cgms_freq_type factors,
  input wire logic bus_clk_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    arvalid && arready;
  endsequence
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  reset_mode_a: assert property (!$past(aresetn) |-> mode == cgms_fei)
    else $error("mode after reset not fll engaged internal");
  bus_half_a: assert property ($past(aresetn, 2) |->
    bus_clk_en != $past(bus_clk_en)) else $error("bus enable not toggling");
  fll_mult_a: assert property (mode inside {cgms_fei, cgms_fee}
    |=> factors.mult == 11'd1024) else $error("fll multiplier wrong");
  byp_mult_a: assert property (mode inside {cgms_fbe, cgms_fbi,
    cgms_pbe, cgms_low_power_internal_bypass, cgms_low_power_external_bypass} |=> factors.mult == 11'd1)
    else $error("bypass multiplier wrong");
  mode_entry_a: assert property (mode == cgms_fei |=> mode inside
    {cgms_fei, cgms_fee, cgms_fbe, cgms_fbi})
    else $error("illegal mode reached from reset mode");
  rd_answer_a: assert property (rd_taken |=> rvalid)
    else $error("read answer missing");
  rd_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read data dropped");
  wr_answer_a: assert property (wr_taken |-> ##2 bvalid)
    else $error("write answer missing");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  rd_busy_a: assert property (rvalid |-> !arready)
    else $error("read accepted while busy");
endmodule
bind cgms_core cgms_core_asserts chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid),
  .wready(wready),
  .bvalid(bvalid),
  .bready(bready),
  .arvalid(arvalid),
  .arready(arready),
  .rdata(rdata),
  .rvalid(rvalid),
  .rready(rready),
  .mode(mode),
  .factors(factors),
  .bus_clk_en(bus_clk_en)
);
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the clock generator sequencer
// Assumes: short settle counts set through parameters
// Notes: walks reset, unavailable source, fbi, fbe, low_power_external_bypass, pbe, pee
`timescale 1ns/1ps
`default_nettype none
`include "cgms_map.svh"
module testbench import cgms_pkg::*; ();
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic ext_present, awready, wready, bvalid, arready, rvalid;
  logic bus_clk_en;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, b;
  cgms_mode_type mode;
  cgms_freq_type factors;
  cgms_mode_type mode_s;
  cgms_freq_type fac_s;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  cgms_core #(.osc_start_cyc(4), .lock_cyc(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_present(ext_present), .mode(mode), .factors(factors),
    .bus_clk_en(bus_clk_en)
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // settled copies of the mode outputs, taken mid-cycle
  always @(negedge aclk) begin
    mode_s <= mode;
    fac_s <= factors;
  end
  task results;
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // ready and valid are looked at mid-cycle, released after the edge
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic aw_go, w_go;
    aw_go = 1'b0;
    w_go = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_go && w_go)) begin
      @(negedge aclk);
      aw_go = aw_go || awready;
      w_go = w_go || wready;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    b = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    v = rdata[7:0];
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // reads status until the masked bits match, bounded
  task poll(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] s;
    int i;
    s = ~v;
    i = 0;
    while ((s & m) !== v && i < 100) begin
      rd(`CGMS_OFF_STAT, s);
      i = i + 1;
    end
    chk(s & m, v);
  endtask
  task t_reset;
    rd(`CGMS_OFF_CTRL1, d);
    chk(d, 8'h04);
    rd(`CGMS_OFF_CTRL2, d);
    chk(d, 8'h40);
    rd(`CGMS_OFF_CTRL3, d);
    chk(d, 8'h01);
    rd(`CGMS_OFF_TRIM, d);
    chk(d, 8'h80);
    rd(`CGMS_OFF_STAT, d);
    chk(d & 8'hbf, 8'h10);
    chk(mode_s, cgms_fei);
    chk(fac_s.bus_div, 4'd2);
    rd(8'h14, d);
    chk(r, 2'b10);
    wr(8'h20, 8'h00);
    chk(b, 2'b10);
    wr(`CGMS_OFF_STAT, 8'hfe);
    rd(`CGMS_OFF_STAT, d);
    chk(d & 8'hbf, 8'h10);
    wr(`CGMS_OFF_STAT, 8'h01);
    rd(`CGMS_OFF_STAT, d);
    chk(d & 8'hbf, 8'h11);
    wr(`CGMS_OFF_TRIM, 8'h7a);
    rd(`CGMS_OFF_TRIM, d);
    chk(d, 8'h7a);
  endtask
  // answers held while the master is slow to take them
  task t_stall;
    araddr <= `CGMS_OFF_CTRL2;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(rvalid, 1'b1);
    chk(rdata, 32'h40);
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    @(negedge aclk);
    chk(rvalid, 1'b0);
    @(posedge aclk);
    awaddr <= `CGMS_OFF_CTRL2;
    wdata <= 32'h40;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    repeat (3) @(negedge aclk);
    chk(bvalid, 1'b1);
    chk(bresp, 2'b00);
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    @(negedge aclk);
    chk(bvalid, 1'b0);
    @(posedge aclk);
  endtask
  task t_unavail;
    wr(`CGMS_OFF_CTRL1, 8'h80);
    // status settles one cycle after the write
    repeat (4) @(posedge aclk);
    chk(mode_s, cgms_fei);
    rd(`CGMS_OFF_STAT, d);
    chk(d & 8'h1c, 8'h10);
    wr(`CGMS_OFF_CTRL1, 8'hc4);
    repeat (4) @(posedge aclk);
    rd(`CGMS_OFF_STAT, d);
    chk(d & 8'h1c, 8'h10);
    wr(`CGMS_OFF_CTRL1, 8'h04);
  endtask
  task t_fbi;
    wr(`CGMS_OFF_CTRL1, 8'h44);
    poll(8'h0c, 8'h04);
    chk(mode_s, cgms_fbi);
    chk(fac_s.mult, 11'd1);
    wr(`CGMS_OFF_CTRL2, 8'h48);
    repeat (4) @(posedge aclk);
    chk(mode_s, cgms_low_power_internal_bypass);
    chk(fac_s.bus_div, 4'd2);
    wr(`CGMS_OFF_CTRL2, 8'h40);
    wr(`CGMS_OFF_CTRL1, 8'h04);
    poll(8'h0c, 8'h00);
    chk(mode_s, cgms_fei);
  endtask
  task t_fbe;
    ext_present <= 1'b1;
    wr(`CGMS_OFF_CTRL2, 8'h36);
    poll(8'h02, 8'h02);
    wr(`CGMS_OFF_CTRL1, 8'hb8);
    poll(8'h1c, 8'h08);
    chk(mode_s, cgms_fbe);
    chk(fac_s.ref_div, 8'd128);
    chk(fac_s.bus_div, 4'd1);
    rd(`CGMS_OFF_CTRL1, d);
    chk(d, 8'hb8);
    wr(`CGMS_OFF_CTRL1, 8'h38);
    poll(8'h1c, 8'h00);
    chk(mode_s, cgms_fee);
    chk(fac_s.mult, 11'd1024);
    wr(`CGMS_OFF_CTRL1, 8'hb8);
    poll(8'h1c, 8'h08);
  endtask
  task t_pll;
    wr(`CGMS_OFF_CTRL2, 8'h3e);
    repeat (4) @(posedge aclk);
    chk(mode_s, cgms_low_power_external_bypass);
    wr(`CGMS_OFF_CTRL1, 8'h90);
    wr(`CGMS_OFF_CTRL3, 8'h44);
    chk(mode_s, cgms_low_power_external_bypass);
    wr(`CGMS_OFF_CTRL2, 8'h36);
    poll(8'h20, 8'h20);
    poll(8'h40, 8'h40);
    chk(mode_s, cgms_pbe);
    chk(fac_s.ref_div, 8'd4);
    wr(`CGMS_OFF_CTRL1, 8'h10);
    poll(8'h0c, 8'h0c);
    chk(mode_s, cgms_pee);
    chk(fac_s.mult, 11'd16);
  endtask
  initial begin
    aresetn <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    wstrb <= 4'h0;
    ext_present <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_stall();
    t_unavail();
    t_fbi();
    t_fbe();
    t_pll();
    results();
  end
endmodule
`default_nettype wire
